// *** bench/serial_channel_clock_select_test.sv ***
// Self-checking bench for the serial channel clock selector.
// Assumes the line model drives the pins; registers are reached over APB.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module serial_channel_clock_select_test
  import clock_select_pkg::*;
;
  logic clock, reset, psel, penable, pwrite, frame_sync, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, pin_out, pin_oe, rx_tick, tx_tick, sys_tick;
  logic rx_win, tx_win, crystal_on, rx_al, tx_al;
  pin_group_type pins;
  int errors = 0, cmp_count = 0, seed = 26;
  int tmode[5] = '{0, 3, 4, 7, 2};
  int topt[5] = '{2, 3, 2, 3, 3};
  int tcode[5] = '{0, 2, 0, 1, 0};
  int tdiv[5] = '{1, 4, 1, 2, 16};
  int txen[5] = '{0, 0, 1, 1, 0};
  int rr, xr, rt, tt, st, po;

  serial_line_model u_serial_line_model (.clock(clock), .reset(reset),
    .frame_sync(frame_sync), .pins(pins));
  serial_channel_clock_select u_serial_channel_clock_select (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .transmit_clock_pin_out(pin_out), .transmit_clock_pin_oe(pin_oe),
    .receive_bit_tick(rx_tick), .transmit_bit_tick(tx_tick), .system_tick(sys_tick),
    .receive_window(rx_win), .transmit_window(tx_win), .receive_align(rx_al),
    .transmit_align(tx_al), .crystal_source_enable(crystal_on));

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  task check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : check

  function automatic int near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction : near

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) errors++;
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(q, e);
  endtask : rd

  // Counts pin rises and ticks over 480 cycles, a whole number of pin periods
  task measure;
    logic pr, px;
    {rr, xr, rt, tt, st, po} = '0;
    repeat (40) @(posedge clock);
    pr = pins.receive_clock_pin;
    px = pins.crystal_input_pin;
    repeat (480) begin
      @(posedge clock);
      rr += pins.receive_clock_pin && !pr;
      xr += pins.crystal_input_pin && !px;
      pr = pins.receive_clock_pin;
      px = pins.crystal_input_pin;
      rt += rx_tick;
      tt += tx_tick;
      st += sys_tick;
      po += pin_out && pin_oe;
    end
  endtask : measure

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    end_sim;
  end

  initial begin
    logic [7:0] asg, wid;
    logic [31:0] rv;
    logic prx;
    int n, w, tw, al;
    {reset, psel, penable, pwrite, frame_sync, paddr, pwdata} = '1;
    {psel, penable, pwrite, frame_sync} = '0;
    repeat (2) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    for (int a = 0; a < 8; a++) rd(8'(a * 4), (a == 4 || a == 5) ? 7 : 0);
    apb(1, 8'h24, 32'hFFFF_FFFF);
    `CHK(err, 1);
    rd(8'h24, 0);
    repeat (4) begin
      rv = 32'($random(seed)) & 32'h7FF;
      apb(1, 8'h0C, rv);
      rd(8'h0C, rv);
    end
    for (int m = 0; m < 8; m++) begin
      apb(1, 8'h00, m);
      // Setup only switches in a tick-free cycle; let it settle before reading
      repeat (8) @(posedge clock);
      apb(0, 8'h20, 0);
      `CHK(q[2:0], m);
    end
    $display("registers done");
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h00, tmode[i]);
      apb(1, 8'h04, topt[i]);
      apb(1, 8'h0C, tcode[i]);
      measure;
      `CHK(crystal_on, txen[i]);
      `CHK(pin_oe, tmode[i] != 0);
      `CHK(near(rt, (txen[i] ? xr : rr) / tdiv[i]), 1);
      if (tmode[i] != 0) `CHK(near(tt, rt), 1);
      if (tmode[i] != 0) `CHK(near(po, tt), 1);
      `CHK(near(st, tt), 1);
      $display("mode %0d done", tmode[i]);
    end
    apb(1, 8'h00, 3);
    apb(1, 8'h0C, 2);
    apb(1, 8'h08, 1);
    repeat (8) @(posedge clock);
    apb(0, 8'h20, 0);
    `CHK(q[5], 1);
    measure;
    `CHK(near(st, xr), 1);
    `CHK(near(rt, rr / 4), 1);
    apb(1, 8'h08, 0);
    $display("master clock done");
    asg = 8'($random(seed)) & 8'h0F;
    wid = 8'($random(seed)) & 8'h0F;
    apb(1, 8'h00, 5);
    apb(1, 8'h04, 2);
    apb(1, 8'h18, asg);
    apb(1, 8'h10, wid);
    apb(1, 8'h1C, 8'h04);
    {n, w, tw, al} = '0;
    prx = pins.receive_clock_pin;
    frame_sync <= 1;
    repeat (2000) begin
      @(posedge clock);
      if (n > 12) frame_sync <= 0;
      // Line clock periods before the window opens, counted at the pin
      if (rx_win === 1) w += rx_tick;
      else if (w == 0) n += pins.receive_clock_pin && !prx;
      prx = pins.receive_clock_pin;
      tw += tx_win;
      al += rx_al + tx_al;
      if (pin_oe === 1) `CHK(pin_out, !tx_win);
    end
    `CHK(near(n, 2 * asg + 1), 1);
    `CHK(near(w, wid + 1), 1);
    `CHK(near(tw / 10, 8), 1);
    `CHK(al, 2);
    $display("time slot done");
    end_sim;
  end
endmodule : serial_channel_clock_select_test

// *** bench/serial_line_model.sv ***
// Far side of one serial channel: line clock, transmit clock, crystal, frame sync, data.
// Assumes the bench clock; every pin changes just after a rising edge.
`timescale 1ns/1ps
module serial_line_model
  import clock_select_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic frame_sync,
  output pin_group_type pins
);
  logic [7:0] phase;
  int seed = 26;

  // Period 120 is a common multiple of 10, 12 and 8, so no clock glitches at wrap
  always_ff @(posedge clock) begin
    if (reset) begin
      phase <= 8'h00;
      pins <= '0;
    end else begin
      phase <= (phase == 8'h77) ? 8'h00 : phase + 8'h01;
      pins.receive_clock_pin <= (phase % 8'h0A) < 8'h05;
      pins.transmit_clock_pin <= (phase % 8'h0C) < 8'h06;
      pins.crystal_input_pin <= phase[2];
      pins.carrier_strobe_pin <= frame_sync;
      if (phase % 8'h0A == 8'h00) begin
        pins.receive_data_pin <= 1'($random(seed));
      end
    end
  end
endmodule : serial_line_model

// *** core/baud_generator.sv ***
// Programmable baud generator: divides a stream of source ticks.
// Assumes source_tick is a one-cycle pulse on clock; divisor 1,2,4,6..2048.
`timescale 1ns/1ps
`include "clock_select_defines.svh"

module baud_generator
  import clock_select_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic source_tick,
  input wire logic [`DIVIDER_BITS-1:0] baud_divider_value,
  output logic tick
);

  logic [`DIVIDER_BITS:0] count;
  logic [`DIVIDER_BITS:0] terminal;

  // Code 0 divides by one, code k by 2k
  assign terminal = (baud_divider_value == '0) ? '0 :
                    {baud_divider_value, 1'b0} - {{`DIVIDER_BITS{1'b0}}, 1'b1};

  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (source_tick) begin
        if (count >= terminal) begin
          count <= '0;
          tick <= 1'b1;
        end else begin
          count <= count + {{`DIVIDER_BITS{1'b0}}, 1'b1};
        end
      end
    end
  end

  a_divide_by_one: assert property (@(posedge clock) disable iff (reset)
    (baud_divider_value == '0) && $stable(baud_divider_value) && source_tick |=> tick)
    else $error("baud generator missed a tick at divisor one");

  a_tick_from_source: assert property (@(posedge clock) disable iff (reset)
    tick |-> $past(source_tick))
    else $error("baud generator ticked without a source tick");

endmodule : baud_generator

// *** core/clock_select_defines.svh ***
// Constants of the serial channel clock selector: register map, field
// positions, reset values and counter widths.
// Assumes inclusion by the package and the design modules only.
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH

`define ADDR_CLOCK_MODE_CONFIG 8'h00
`define ADDR_CLOCK_OPTION_CONFIG 8'h04
`define ADDR_CHANNEL_BASE_CONFIG 8'h08
`define ADDR_BAUD_DIVIDER_VALUE 8'h0C
`define ADDR_RECEIVE_SLOT_WIDTH 8'h10
`define ADDR_TRANSMIT_SLOT_WIDTH 8'h14
`define ADDR_RECEIVE_SLOT_ASSIGN 8'h18
`define ADDR_TRANSMIT_SLOT_ASSIGN 8'h1C
`define ADDR_CLOCK_STATUS 8'h20

`define OPT_SOURCE_SELECT 0
`define OPT_TRANSMIT_OUTPUT 1
`define OPT_TRANSMIT_SHIFT_LSB 2
`define OPT_RECEIVE_SHIFT_LSB 3
`define MODE_ONE_INSERTION 3
`define BASE_MASTER_CLOCK 0

`define RESET_MODE 3'h0
`define RESET_OPTION 4'h0
`define RESET_DIVIDER 11'h000
`define RESET_SLOT_WIDTH 8'h07
`define RESET_SLOT_ASSIGN 8'h00

// Code 1024 is needed to reach the divide-by-2048 end of the range
`define DIVIDER_BITS 11
`define SLOT_COUNT_BITS 10
`define RECOVERY_PERIOD 4'hF
`define RECOVERY_SAMPLE 4'h7

`endif

// *** core/clock_select_pkg.sv ***
// Types shared by the clock selector modules.
// Assumes the constants header sits beside it.
`include "clock_select_defines.svh"

package clock_select_pkg;

  typedef enum logic [2:0] {
    MODE_EXTERNAL = 3'b000,
    MODE_STROBES = 3'b001,
    MODE_RECOVER_RX = 3'b010,
    MODE_RECOVER_BOTH = 3'b011,
    MODE_OSCILLATOR = 3'b100,
    MODE_TIME_SLOT = 3'b101,
    MODE_OSC_RECOVER_RX = 3'b110,
    MODE_OSC_RECOVER_BOTH = 3'b111
  } clock_mode_type;

  typedef struct packed {
    clock_mode_type mode;
    logic source_select;
    logic transmit_clock_output_enable;
    logic master_clock_enable;
  } clock_setup_type;

  typedef struct packed {
    logic receive_clock_pin;
    logic transmit_clock_pin;
    logic crystal_input_pin;
    logic carrier_strobe_pin;
    logic receive_data_pin;
  } pin_group_type;

endpackage : clock_select_pkg

// *** core/serial_channel_clock_select.sv ***
// Clock selection for one serial channel: picks receive, transmit and system
// bit ticks among pins, crystal, baud generator and clock recovery.
// Assumes an APB master on clock; all pins are asynchronous to clock and are
// turned into one-cycle ticks on their rising edges.
//
// Behaviour
// - Eight clock modes chosen by the mode field fix sources and pin use.
// - Each channel has its own baud generator and recovery loop.
// - Recovery loop is fed by baud generator; divisor 1, 2, 4, 6..2048.
// - System tick follows transmit clock, or master clock when enabled outside mode 5.
// - Outside mode 5, master clock enable takes system tick from the crystal input.
// - Bit ticks stay on their own sources while master clock runs.
// - Mode 0: receive from pin; transmit from pin or crystal baud.
// - Mode 1: receive pin clocks both ways, gated by per-bit strobes.
// - Strobes of mode 1 also mark byte alignment.
// - Mode 2: recovered receive; transmit from pin or baud over 16.
// - Mode 3: both from recovery, or both from baud when select set.
// - Mode 4: both directions straight from the crystal.
// - Transmit clock pin drives only in output modes with enable set.
// - Mode 5: common pin clock, windows of 1 to 256 bits.
// - Mode 5: 64 slots, shift 0..7 and shift lsb make 9 bits.
// - Mode 5: window opens 1 to 512 periods after frame sync.
// - Mode 5: transmit clock pin low exactly during transmit window.
// - Mode 6 is mode 2 with baud generator fed by crystal.
// - Mode 7 is mode 3 with baud generator fed by crystal.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "clock_select_defines.svh"

module serial_channel_clock_select
  import clock_select_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pin_group_type pins,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe,
  output logic receive_bit_tick,
  output logic transmit_bit_tick,
  output logic system_tick,
  output logic receive_window,
  output logic transmit_window,
  output logic receive_align,
  output logic transmit_align,
  output logic crystal_source_enable
);

  // Registers
  logic [3:0] clock_mode_config;
  logic [3:0] clock_option_config;
  logic [0:0] channel_base_config;
  logic [`DIVIDER_BITS-1:0] baud_divider_value;
  logic [7:0] receive_slot_width;
  logic [7:0] transmit_slot_width;
  logic [7:0] receive_slot_assign;
  logic [7:0] transmit_slot_assign;

  clock_setup_type requested;
  clock_setup_type active;
  pin_group_type sync_first;
  pin_group_type sync_second;
  pin_group_type sync_last;
  pin_group_type rise;

  logic mapped;
  logic [31:0] next_prdata;
  logic brg_source_tick;
  logic brg_tick;
  logic [3:0] brg16_count;
  logic brg16_tick;
  logic [3:0] recovery_count;
  logic recovery_tick;
  logic next_rx_tick;
  logic next_tx_tick;
  logic any_tick;
  logic master_effective;
  logic [`SLOT_COUNT_BITS-1:0] slot_count;
  logic [8:0] rx_location;
  logic [8:0] tx_location;
  logic [`SLOT_COUNT_BITS-1:0] rx_open;
  logic [`SLOT_COUNT_BITS-1:0] tx_open;
  logic [`SLOT_COUNT_BITS-1:0] rx_close;
  logic [`SLOT_COUNT_BITS-1:0] tx_close;
  logic next_rx_window;
  logic next_tx_window;
  logic output_mode;
  logic output_source;
  logic frame_sync;

  // APB slave, no wait state: answer registered in the setup cycle
  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `ADDR_CLOCK_MODE_CONFIG: next_prdata[3:0] = clock_mode_config;
      `ADDR_CLOCK_OPTION_CONFIG: next_prdata[3:0] = clock_option_config;
      `ADDR_CHANNEL_BASE_CONFIG: next_prdata[0] = channel_base_config[0];
      `ADDR_BAUD_DIVIDER_VALUE: next_prdata[`DIVIDER_BITS-1:0] = baud_divider_value;
      `ADDR_RECEIVE_SLOT_WIDTH: next_prdata[7:0] = receive_slot_width;
      `ADDR_TRANSMIT_SLOT_WIDTH: next_prdata[7:0] = transmit_slot_width;
      `ADDR_RECEIVE_SLOT_ASSIGN: next_prdata[7:0] = receive_slot_assign;
      `ADDR_TRANSMIT_SLOT_ASSIGN: next_prdata[7:0] = transmit_slot_assign;
      `ADDR_CLOCK_STATUS: next_prdata[7:0] = {receive_window, transmit_window,
                                              master_effective, active.source_select,
                                              1'b0, active.mode};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      clock_mode_config <= {1'b0, `RESET_MODE};
      clock_option_config <= `RESET_OPTION;
      channel_base_config <= 1'b0;
      baud_divider_value <= `RESET_DIVIDER;
      receive_slot_width <= `RESET_SLOT_WIDTH;
      transmit_slot_width <= `RESET_SLOT_WIDTH;
      receive_slot_assign <= `RESET_SLOT_ASSIGN;
      transmit_slot_assign <= `RESET_SLOT_ASSIGN;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        `ADDR_CLOCK_MODE_CONFIG: clock_mode_config <= pwdata[3:0];
        `ADDR_CLOCK_OPTION_CONFIG: clock_option_config <= pwdata[3:0];
        `ADDR_CHANNEL_BASE_CONFIG: channel_base_config <= pwdata[0:0];
        `ADDR_BAUD_DIVIDER_VALUE: baud_divider_value <= pwdata[`DIVIDER_BITS-1:0];
        `ADDR_RECEIVE_SLOT_WIDTH: receive_slot_width <= pwdata[7:0];
        `ADDR_TRANSMIT_SLOT_WIDTH: transmit_slot_width <= pwdata[7:0];
        `ADDR_RECEIVE_SLOT_ASSIGN: receive_slot_assign <= pwdata[7:0];
        `ADDR_TRANSMIT_SLOT_ASSIGN: transmit_slot_assign <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers; edges are taken between the second and last stages
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_first <= '0;
      sync_second <= '0;
      sync_last <= '0;
    end else begin
      sync_first <= pins;
      sync_second <= sync_first;
      sync_last <= sync_second;
    end
  end

  assign rise = sync_second & ~sync_last;
  assign frame_sync = rise.carrier_strobe_pin;

  // Setup takes effect only in a cycle with no source tick, so no tick is
  // ever cut short or doubled by a mux change
  assign requested.mode = clock_mode_type'(clock_mode_config[2:0]);
  assign requested.source_select = clock_option_config[`OPT_SOURCE_SELECT];
  assign requested.transmit_clock_output_enable = clock_option_config[`OPT_TRANSMIT_OUTPUT];
  assign requested.master_clock_enable = channel_base_config[`BASE_MASTER_CLOCK];
  assign any_tick = |rise || brg_tick || recovery_tick;

  always_ff @(posedge clock) begin
    if (reset) begin
      active <= '0;
    end else if (!any_tick) begin
      active <= requested;
    end
  end

  // Baud source: crystal in modes 0, 4, 6, 7; receive clock pin otherwise
  always_comb begin
    case (active.mode)
      MODE_EXTERNAL, MODE_OSCILLATOR, MODE_OSC_RECOVER_RX,
      MODE_OSC_RECOVER_BOTH: brg_source_tick = rise.crystal_input_pin;
      default: brg_source_tick = rise.receive_clock_pin;
    endcase
  end

  baud_generator baud_generator_unit (
    .clock(clock),
    .reset(reset),
    .source_tick(brg_source_tick),
    .baud_divider_value(baud_divider_value),
    .tick(brg_tick)
  );

  // Baud output over 16 for the transmit side
  always_ff @(posedge clock) begin
    if (reset) begin
      brg16_count <= 4'h0;
    end else if (brg_tick) begin
      brg16_count <= brg16_count + 4'h1;
    end
  end

  assign brg16_tick = brg_tick && (brg16_count == `RECOVERY_PERIOD);

  // Clock recovery: 16 references per bit, sample mid-bit, re-phase on a
  // data edge; a second edge inside the same bit is treated as a spike
  logic edge_seen;

  always_ff @(posedge clock) begin
    if (reset) begin
      recovery_count <= 4'h0;
      edge_seen <= 1'b0;
    end else begin
      if ((sync_second.receive_data_pin != sync_last.receive_data_pin) && !edge_seen) begin
        recovery_count <= 4'h0;
        edge_seen <= 1'b1;
      end else if (brg_tick) begin
        recovery_count <= recovery_count + 4'h1;
        if (recovery_count == `RECOVERY_PERIOD) begin
          edge_seen <= 1'b0;
        end
      end
    end
  end

  assign recovery_tick = brg_tick && (recovery_count == `RECOVERY_SAMPLE);

  // Bit tick selection per mode
  always_comb begin
    next_rx_tick = 1'b0;
    next_tx_tick = 1'b0;
    output_mode = 1'b0;
    output_source = 1'b0;
    case (active.mode)
      MODE_EXTERNAL: begin
        next_rx_tick = rise.receive_clock_pin;
        next_tx_tick = active.source_select ? brg_tick : rise.transmit_clock_pin;
        output_mode = active.source_select;
        output_source = brg_tick;
      end
      MODE_STROBES: begin
        next_rx_tick = rise.receive_clock_pin && sync_second.carrier_strobe_pin;
        next_tx_tick = rise.receive_clock_pin && sync_second.transmit_clock_pin;
      end
      MODE_RECOVER_RX, MODE_OSC_RECOVER_RX: begin
        next_rx_tick = recovery_tick;
        next_tx_tick = active.source_select ? brg16_tick : rise.transmit_clock_pin;
        output_mode = active.source_select;
        output_source = brg16_tick;
      end
      MODE_RECOVER_BOTH, MODE_OSC_RECOVER_BOTH: begin
        next_rx_tick = active.source_select ? brg_tick : recovery_tick;
        next_tx_tick = next_rx_tick;
        output_mode = 1'b1;
        output_source = next_rx_tick;
      end
      MODE_OSCILLATOR: begin
        next_rx_tick = rise.crystal_input_pin;
        next_tx_tick = rise.crystal_input_pin;
        output_mode = 1'b1;
        output_source = rise.crystal_input_pin;
      end
      MODE_TIME_SLOT: begin
        next_rx_tick = rise.receive_clock_pin && receive_window;
        next_tx_tick = rise.receive_clock_pin && transmit_window;
      end
      default: ;
    endcase
  end

  // Master clock is refused in time-slot mode
  assign master_effective = active.master_clock_enable && (active.mode != MODE_TIME_SLOT);

  always_ff @(posedge clock) begin
    if (reset) begin
      receive_bit_tick <= 1'b0;
      transmit_bit_tick <= 1'b0;
      system_tick <= 1'b0;
      crystal_source_enable <= 1'b0;
    end else begin
      receive_bit_tick <= next_rx_tick;
      transmit_bit_tick <= next_tx_tick;
      system_tick <= master_effective ? rise.crystal_input_pin : next_tx_tick;
      crystal_source_enable <= master_effective ||
                               (active.mode == MODE_OSCILLATOR ||
                                active.mode == MODE_OSC_RECOVER_RX ||
                                active.mode == MODE_OSC_RECOVER_BOTH ||
                                (active.mode == MODE_EXTERNAL && active.source_select));
    end
  end

  // Time-slot windows: count receive clock periods since frame sync
  assign rx_location = {receive_slot_assign, clock_option_config[`OPT_RECEIVE_SHIFT_LSB]};
  assign tx_location = {transmit_slot_assign, clock_option_config[`OPT_TRANSMIT_SHIFT_LSB]};
  assign rx_open = {1'b0, rx_location} + `SLOT_COUNT_BITS'(1);
  assign tx_open = {1'b0, tx_location} + `SLOT_COUNT_BITS'(1);
  assign rx_close = rx_open + {2'b00, receive_slot_width};
  assign tx_close = tx_open + {2'b00, transmit_slot_width};

  always_ff @(posedge clock) begin
    if (reset) begin
      slot_count <= '1;
    end else if (frame_sync) begin
      slot_count <= '0;
    end else if (rise.receive_clock_pin && slot_count != '1) begin
      slot_count <= slot_count + `SLOT_COUNT_BITS'(1);
    end
  end

  assign next_rx_window = (active.mode == MODE_TIME_SLOT) &&
                          (slot_count >= rx_open) && (slot_count <= rx_close) &&
                          (slot_count != '1);
  assign next_tx_window = (active.mode == MODE_TIME_SLOT) &&
                          (slot_count >= tx_open) && (slot_count <= tx_close) &&
                          (slot_count != '1);

  always_ff @(posedge clock) begin
    if (reset) begin
      receive_window <= 1'b0;
      transmit_window <= 1'b0;
      receive_align <= 1'b0;
      transmit_align <= 1'b0;
    end else begin
      receive_window <= next_rx_window;
      transmit_window <= next_tx_window;
      receive_align <= (next_rx_window && !receive_window) ||
                       (active.mode == MODE_STROBES && rise.carrier_strobe_pin);
      transmit_align <= (next_tx_window && !transmit_window) ||
                        (active.mode == MODE_STROBES && rise.transmit_clock_pin);
    end
  end

  // Transmit clock pin: pulse per output tick, or slot indication in mode 5
  always_ff @(posedge clock) begin
    if (reset) begin
      transmit_clock_pin_out <= 1'b1;
      transmit_clock_pin_oe <= 1'b0;
    end else if (active.mode == MODE_TIME_SLOT) begin
      transmit_clock_pin_out <= !next_tx_window;
      transmit_clock_pin_oe <= active.transmit_clock_output_enable;
    end else begin
      transmit_clock_pin_out <= output_source;
      transmit_clock_pin_oe <= output_mode && active.transmit_clock_output_enable;
    end
  end

  default clocking main_clock @(posedge clock); endclocking
  default disable iff (reset);

  a_mode4_both_ticks: assert property (
    active.mode == MODE_OSCILLATOR && rise.crystal_input_pin
      |=> receive_bit_tick && transmit_bit_tick)
    else $error("crystal edge did not tick both directions in mode 4");

  a_strobe_gates_rx: assert property (
    active.mode == MODE_STROBES && rise.receive_clock_pin && !sync_second.carrier_strobe_pin
      |=> !receive_bit_tick)
    else $error("receive tick passed a closed strobe");

  a_master_system: assert property (
    master_effective && rise.crystal_input_pin |=> system_tick)
    else $error("master clock edge gave no system tick");

  a_system_from_tx: assert property (
    !master_effective ##0 $stable(active) |=> system_tick == transmit_bit_tick)
    else $error("system tick left the transmit clock");

  a_pin_quiet_strobes: assert property (
    active.mode == MODE_STROBES ##1 active.mode == MODE_STROBES |-> !transmit_clock_pin_oe)
    else $error("transmit clock pin driven while it is a strobe input");

  a_slot_pin_low: assert property (
    active.mode == MODE_TIME_SLOT && $past(active.mode == MODE_TIME_SLOT)
      |-> transmit_clock_pin_out == !transmit_window)
    else $error("slot indication differs from transmit window");

  a_window_opens: assert property (
    $rose(transmit_window) && $stable(transmit_slot_assign)
      |-> $past(slot_count) == $past(tx_open))
    else $error("transmit window opened at the wrong period");

  a_switch_no_tick: assert property (
    active != $past(active) |-> !$past(any_tick))
    else $error("clock setup switched on a tick");

  a_recover_rx: assert property (
    active.mode == MODE_RECOVER_RX && recovery_tick ##1 active.mode == MODE_RECOVER_RX
      |-> receive_bit_tick)
    else $error("recovered tick lost in mode 2");

  c_slot_window: cover property ($rose(transmit_window) ##[1:300] $fell(transmit_window));
  c_master_tick: cover property (master_effective && system_tick);
  c_recovery_tick: cover property (active.mode == MODE_OSC_RECOVER_BOTH && receive_bit_tick);

endmodule : serial_channel_clock_select
